// file: hw/clkgen_pkg.sv
// Constants and types shared by the clock generation block and its divider.
package clkgen_pkg;
  localparam int MULT_W = 7;
  localparam int SYS_DIV_W = 4;
  localparam int CORE_SEL_W = 2;
  localparam int REGULATOR_FREQUENCY_FIELD_W = 2;
  localparam logic [MULT_W-1:0] MULT_MIN = 7'h05;
  localparam logic [MULT_W-1:0] MULT_MAX = 7'h40;
  localparam logic [MULT_W-1:0] MULT_RESET = 7'h06;
  localparam logic [SYS_DIV_W-1:0] SYS_DIV_RESET = 4'h6;
  localparam logic [SYS_DIV_W-1:0] SYS_DIV_ZERO = 4'h0;
  localparam logic [SYS_DIV_W-1:0] DIV_ONE = 4'h1;
  localparam logic [CORE_SEL_W-1:0] CORE_SEL_RESET = 2'h0;
  localparam logic [REGULATOR_FREQUENCY_FIELD_W-1:0] REGULATOR_FREQUENCY_FIELD_HIBERNATE = 2'h0;

  typedef enum logic [1:0] {
    PWR_WAIT_GOOD = 2'b00,
    PWR_RUNNING = 2'b01,
    PWR_HIBERNATE = 2'b10
  } power_state_t;
endpackage

// file: hw/glitchless_divider.sv
// Divider that turns a stream of edge ticks into a clock, switching ratio glitch-free.
`timescale 1ns/100ps
`default_nettype none
module glitchless_divider #(
  parameter int DIV_W = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic run,
  input wire logic tick,
  input wire logic [DIV_W-1:0] div,
  output logic system_clock_ref_out
);
  import clkgen_pkg::*;

  localparam logic [DIV_W-1:0] STEP = {{(DIV_W-1){1'b0}}, 1'b1};

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] curDiv;

  // Each output phase lasts curDiv ticks; while running, a new ratio is taken only at a rising edge,
  // so a ratio change never cuts a high or low phase short. Dropping run forces the output low at once.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      curDiv <= STEP;
      system_clock_ref_out <= 1'h0;
    end else if (ce) begin
      if (!run) begin
        cnt <= '0;
        system_clock_ref_out <= 1'h0;
        curDiv <= div;
      end else if (tick) begin
        if (cnt >= curDiv - STEP) begin
          cnt <= '0;
          system_clock_ref_out <= ~system_clock_ref_out;
          if (!system_clock_ref_out) begin
            curDiv <= div;
          end
        end else begin
          cnt <= cnt + STEP;
        end
      end
    end
  end

  a_ratio_switch_edge: assert property (@(posedge clk) disable iff (!resetn)
    (run && $past(run) && $changed(curDiv)) |-> $rose(system_clock_ref_out))
    else $error("Divider ratio changed away from a rising edge.");
endmodule
`default_nettype wire

// file: hw/core_system_clock_generation.sv
// Core and system clock generation with regulator wake and power-good handshake.
// Function
// - Wake output high requests core power, low requests power removal.
// - Clocks start only after active-low power-good shows supply ready, also after hibernation.
// - Buffered output carries a copy of the input clock.
// - Multiplier 5 to 64 forms the output clock; 6 after reset.
// - Core and system clocks both derive from the input clock at independent rates.
// - Outside bypass, a divider write changes derived frequencies at their next rising edge, with no sequence.
// - Reference output follows system clock; enabled after reset, disabled by memory controls.
// - All peripherals are clocked from the system clock, not the core clock.
// - System divider field divides the output clock by 1 to 15.
// - System divider changes take effect without waiting for relock.
// - Core field selects divide by 1, 2, 4 or 8.
// - Writing zero to the regulator frequency field drives wake low.
// - While bypassed, core and system clocks run at the input clock rate.
// - Multiplier writes during bypass take effect only once bypass ends.
`timescale 1ns/100ps
`default_nettype none
module core_system_clock_generation #(
  parameter int PERIOD_W = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic inputClock,
  input wire logic powerGoodN,
  input wire logic pllBypass,
  input wire logic multWrite,
  input wire logic [clkgen_pkg::MULT_W-1:0] multValue,
  input wire logic divWrite,
  input wire logic [clkgen_pkg::SYS_DIV_W-1:0] systemDividerField,
  input wire logic [clkgen_pkg::CORE_SEL_W-1:0] coreDividerField,
  input wire logic regFreqWrite,
  input wire logic [clkgen_pkg::REGULATOR_FREQUENCY_FIELD_W-1:0] regulatorFrequencyField,
  input wire logic sdramClockOutDisable,
  input wire logic asyncClockOutDisable,
  output logic regulatorWakeOut,
  output logic coreRunning,
  output logic bufferedInputClockOut,
  output logic pllOutputClock,
  output logic coreClock,
  output logic systemClock,
  output logic systemClockRefOut,
  output logic [clkgen_pkg::MULT_W-1:0] activeMultiplier,
  output logic [clkgen_pkg::SYS_DIV_W-1:0] systemDividerSetting
);
  import clkgen_pkg::*;

  function automatic logic [SYS_DIV_W-1:0] coreRatio(input logic [CORE_SEL_W-1:0] sel);
    logic [SYS_DIV_W-1:0] r;
    r = DIV_ONE << sel;
    return r;
  endfunction

  function automatic logic multInRange(input logic [MULT_W-1:0] m);
    return (m >= MULT_MIN) && (m <= MULT_MAX);
  endfunction

  logic inSync1;
  logic inSync2;
  logic inPrev;
  logic pgSync1;
  logic pgSync2;
  logic inRise;
  logic inEdge;
  power_state_t powerState;
  power_state_t next_powerState;
  logic [MULT_W-1:0] pendingMult;
  logic [CORE_SEL_W-1:0] coreSel;
  logic [PERIOD_W-1:0] periodCnt;
  logic [PERIOD_W-1:0] period;
  logic [PERIOD_W-1:0] acc;
  logic [PERIOD_W:0] ncoSum;
  logic [PERIOD_W:0] ncoRem;
  logic vcoTick;
  logic divTick;
  logic [SYS_DIV_W-1:0] sysDivEff;
  logic [SYS_DIV_W-1:0] coreDivEff;

  // Both pin inputs pass two flip-flops; edge detection reads only the second stage.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inSync1 <= 1'h0;
      inSync2 <= 1'h0;
      inPrev <= 1'h0;
      pgSync1 <= 1'h1;
      pgSync2 <= 1'h1;
    end else if (ce) begin
      inSync1 <= inputClock;
      inSync2 <= inSync1;
      inPrev <= inSync2;
      pgSync1 <= powerGoodN;
      pgSync2 <= pgSync1;
    end
  end

  assign inRise = inSync2 & ~inPrev;
  assign inEdge = inSync2 ^ inPrev;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bufferedInputClockOut <= 1'h0;
    end else if (ce) begin
      bufferedInputClockOut <= inSync2;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regulatorWakeOut <= 1'h1;
    end else if (ce && regFreqWrite) begin
      regulatorWakeOut <= (regulatorFrequencyField != REGULATOR_FREQUENCY_FIELD_HIBERNATE);
    end
  end

  // Leaving hibernation goes back through the power-good wait.
  always_comb begin
    next_powerState = powerState;
    case (powerState)
      PWR_WAIT_GOOD: begin
        if (!regulatorWakeOut) begin
          next_powerState = PWR_HIBERNATE;
        end else if (!pgSync2) begin
          next_powerState = PWR_RUNNING;
        end
      end
      PWR_RUNNING: begin
        if (!regulatorWakeOut) begin
          next_powerState = PWR_HIBERNATE;
        end
      end
      PWR_HIBERNATE: begin
        if (regulatorWakeOut) begin
          next_powerState = PWR_WAIT_GOOD;
        end
      end
      default: begin
        next_powerState = PWR_WAIT_GOOD;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      powerState <= PWR_WAIT_GOOD;
      coreRunning <= 1'h0;
    end else if (ce) begin
      powerState <= next_powerState;
      coreRunning <= (next_powerState == PWR_RUNNING);
    end
  end

  // A multiplier written during bypass waits in pendingMult until bypass ends.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pendingMult <= MULT_RESET;
      activeMultiplier <= MULT_RESET;
    end else if (ce) begin
      if (multWrite && multInRange(multValue)) begin
        pendingMult <= multValue;
      end
      if (!pllBypass) begin
        activeMultiplier <= pendingMult;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      systemDividerSetting <= SYS_DIV_RESET;
      coreSel <= CORE_SEL_RESET;
    end else if (ce && divWrite) begin
      if (systemDividerField != SYS_DIV_ZERO) begin
        systemDividerSetting <= systemDividerField;
      end
      coreSel <= coreDividerField;
    end
  end

  // Input clock period in clk cycles, measured between synchronised rising edges.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      periodCnt <= '0;
      period <= '0;
    end else if (ce) begin
      if (inRise) begin
        periodCnt <= '0;
        period <= periodCnt + {{(PERIOD_W-1){1'b0}}, 1'b1};
      end else if (periodCnt != {PERIOD_W{1'b1}}) begin
        periodCnt <= periodCnt + {{(PERIOD_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // The oscillator ticks on every output clock edge: twice the multiplier per input period.
  assign ncoSum = {1'b0, acc} + {{(PERIOD_W-MULT_W){1'b0}}, activeMultiplier, 1'b0};
  assign ncoRem = ncoSum - {1'b0, period};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc <= '0;
      vcoTick <= 1'h0;
    end else if (ce) begin
      if (!coreRunning || pllBypass || (period == '0)) begin
        acc <= '0;
        vcoTick <= 1'h0;
      end else if (ncoSum >= {1'b0, period}) begin
        acc <= (ncoRem >= {1'b0, period}) ? '0 : ncoRem[PERIOD_W-1:0];
        vcoTick <= 1'h1;
      end else begin
        acc <= ncoSum[PERIOD_W-1:0];
        vcoTick <= 1'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pllOutputClock <= 1'h0;
    end else if (ce && vcoTick) begin
      pllOutputClock <= ~pllOutputClock;
    end
  end

  // Bypass feeds input clock edges straight to the dividers at a ratio of one.
  assign divTick = pllBypass ? inEdge : vcoTick;
  assign sysDivEff = pllBypass ? DIV_ONE : systemDividerSetting;
  assign coreDivEff = pllBypass ? DIV_ONE : coreRatio(coreSel);

  glitchless_divider #(.DIV_W(SYS_DIV_W)) coreDivider (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .run(coreRunning),
    .tick(divTick),
    .div(coreDivEff),
    .system_clock_ref_out(coreClock)
  );

  // This divided clock is the one every peripheral uses.
  glitchless_divider #(.DIV_W(SYS_DIV_W)) systemDivider (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .run(coreRunning),
    .tick(divTick),
    .div(sysDivEff),
    .system_clock_ref_out(systemClock)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      systemClockRefOut <= 1'h0;
    end else if (ce) begin
      systemClockRefOut <= systemClock & ~(sdramClockOutDisable | asyncClockOutDisable);
    end
  end

  sequence s_hibernate_exit;
    !regulatorWakeOut ##1 regulatorWakeOut;
  endsequence

  a_wake_on_regulator_frequency_field: assert property (@(posedge clk) disable iff (!resetn)
    (ce && regFreqWrite && regulatorFrequencyField == REGULATOR_FREQUENCY_FIELD_HIBERNATE) |=> !regulatorWakeOut)
    else $error("Wake output not low after hibernate write.");

  a_wake_powerup: assert property (@(posedge clk) disable iff (!resetn)
    (ce && regFreqWrite && regulatorFrequencyField != REGULATOR_FREQUENCY_FIELD_HIBERNATE) |=> regulatorWakeOut)
    else $error("Wake output not high after non-zero frequency write.");

  a_start_needs_good: assert property (@(posedge clk) disable iff (!resetn)
    $rose(coreRunning) |-> ($past(pgSync2) == 1'b0) && $past(regulatorWakeOut))
    else $error("Clocks started without power good.");

  a_hib_exit_waits: assert property (@(posedge clk) disable iff (!resetn)
    s_hibernate_exit |-> !coreRunning)
    else $error("Clocks running right after hibernation exit.");

  a_mult_in_range: assert property (@(posedge clk) disable iff (!resetn)
    (activeMultiplier >= MULT_MIN) && (activeMultiplier <= MULT_MAX))
    else $error("Active multiplier out of range.");

  a_bypass_holds_mult: assert property (@(posedge clk) disable iff (!resetn)
    pllBypass |=> $stable(activeMultiplier))
    else $error("Multiplier changed during bypass.");

  a_sysdiv_zero_kept: assert property (@(posedge clk) disable iff (!resetn)
    (divWrite && systemDividerField == SYS_DIV_ZERO) |=> $stable(systemDividerSetting))
    else $error("Zero system divider was accepted.");

  a_div_write_applies: assert property (@(posedge clk) disable iff (!resetn)
    (ce && divWrite && systemDividerField != SYS_DIV_ZERO)
      |=> systemDividerSetting == $past(systemDividerField))
    else $error("System divider write not applied.");

  a_ref_disabled: assert property (@(posedge clk) disable iff (!resetn)
    (ce && (sdramClockOutDisable || asyncClockOutDisable)) |=> !systemClockRefOut)
    else $error("Reference output active while disabled.");
endmodule
`default_nettype wire

// file: verif/regulator_source_model.sv
// Model of the external core regulator and the input clock source.
`timescale 1ns/100ps
`default_nettype none
module regulator_source_model #(
  parameter int HALF_NS = 80,
  parameter int GOOD_DELAY = 20
) (
  input wire logic clk,
  input wire logic regulatorWakeOut,
  output logic inputClock,
  output logic powerGoodN
);
  int rampCount = 0;
  initial begin
    inputClock = 1'b0;
    forever #(HALF_NS) inputClock = ~inputClock;
  end
  // The supply needs time to ramp before power good drops; shutdown is seen at once.
  always @(posedge clk) begin
    if (!regulatorWakeOut) begin
      rampCount <= 0;
      powerGoodN <= #1 1'b1;
    end else if (rampCount < GOOD_DELAY) begin
      rampCount <= rampCount + 1;
      powerGoodN <= #1 1'b1;
    end else begin
      powerGoodN <= #1 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: verif/core_system_clock_generation_test.sv
// Self-checking bench for the core and system clock generation block.
`timescale 1ns/100ps
`default_nettype none
module core_system_clock_generation_test;
  import clkgen_pkg::*;
  typedef struct {logic [3:0] sys; logic [1:0] core; logic [3:0] expSet;} row_t;
  logic clk, resetn, ce, inputClock, powerGoodN, pllBypass, multWrite, divWrite;
  logic regFreqWrite, sdramClockOutDisable, asyncClockOutDisable;
  logic regulatorWakeOut, coreRunning, bufferedInputClockOut, pllOutputClock;
  logic coreClock, systemClock, systemClockRefOut;
  logic [MULT_W-1:0] multValue, activeMultiplier;
  logic [SYS_DIV_W-1:0] systemDividerField, systemDividerSetting;
  logic [CORE_SEL_W-1:0] coreDividerField;
  logic [REGULATOR_FREQUENCY_FIELD_W-1:0] regulatorFrequencyField;
  logic [5:0] clkVec;
  int failCount = 0;
  int samplesChecked = 0;
  int cnt[6];
  // Dividers stay within the supported range, zero being the refused case.
  row_t rows[6] = '{'{4'h2, 2'h0, 4'h2}, '{4'h6, 2'h1, 4'h6}, '{4'ha, 2'h2, 4'ha},
    '{4'hf, 2'h3, 4'hf}, '{4'h0, 2'h0, 4'hf}, '{4'h1, 2'h1, 4'h1}};
  assign clkVec = {bufferedInputClockOut, inputClock, systemClockRefOut, systemClock,
    coreClock, pllOutputClock};
  core_system_clock_generation core_system_clock_generation_i (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .inputClock(inputClock),
    .powerGoodN(powerGoodN),
    .pllBypass(pllBypass),
    .multWrite(multWrite),
    .multValue(multValue),
    .divWrite(divWrite),
    .systemDividerField(systemDividerField),
    .coreDividerField(coreDividerField),
    .regFreqWrite(regFreqWrite),
    .regulatorFrequencyField(regulatorFrequencyField),
    .sdramClockOutDisable(sdramClockOutDisable),
    .asyncClockOutDisable(asyncClockOutDisable),
    .regulatorWakeOut(regulatorWakeOut),
    .coreRunning(coreRunning),
    .bufferedInputClockOut(bufferedInputClockOut),
    .pllOutputClock(pllOutputClock),
    .coreClock(coreClock),
    .systemClock(systemClock),
    .systemClockRefOut(systemClockRefOut),
    .activeMultiplier(activeMultiplier),
    .systemDividerSetting(systemDividerSetting)
  );
  regulator_source_model regulator_source_model_i (.clk(clk),
    .regulatorWakeOut(regulatorWakeOut), .inputClock(inputClock), .powerGoodN(powerGoodN));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic near(input int got, input int exp, input int tol);
    samplesChecked++;
    if (got > exp + tol || got < exp - tol) begin
      failCount++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic measure(input int n);
    logic [5:0] prev;
    cnt = '{default:0};
    prev = clkVec;
    repeat (n) begin
      @(posedge clk);
      for (int i = 0; i < 6; i++) cnt[i] += int'(clkVec[i] & !prev[i]);
      prev = clkVec;
    end
    #1;
  endtask
  task automatic setDiv(input logic [3:0] s, input logic [1:0] c);
    systemDividerField = s;
    coreDividerField = c;
    divWrite = 1'b1;
    step(1);
    divWrite = 1'b0;
  endtask
  task automatic setMult(input logic [6:0] m);
    multValue = m;
    multWrite = 1'b1;
    step(1);
    multWrite = 1'b0;
  endtask
  task automatic setFreq(input logic [1:0] f);
    regulatorFrequencyField = f;
    regFreqWrite = 1'b1;
    step(1);
    regFreqWrite = 1'b0;
  endtask
  task automatic waitRunning();
    for (int i = 0; i < 200 && coreRunning !== 1'b1; i++) step(1);
    chk(16'(coreRunning), 16'h0001);
  endtask
  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // The whole sequence needs about 6000 cycles; the watchdog allows a wide margin.
  initial begin
    #(20000 * 8);
    failCount++;
    finalReport();
  end
  initial begin
    {resetn, pllBypass, multWrite, divWrite, regFreqWrite} = '0;
    {sdramClockOutDisable, asyncClockOutDisable} = '0;
    ce = 1'b1;
    multValue = MULT_RESET;
    systemDividerField = SYS_DIV_RESET;
    coreDividerField = CORE_SEL_RESET;
    regulatorFrequencyField = 2'h1;
    step(6);
    resetn = 1'b1;
    step(2);
    chk(16'(regulatorWakeOut), 16'h0001);
    chk(16'(coreRunning), 16'h0000);
    chk(16'(activeMultiplier), 16'(MULT_RESET));
    chk(16'(systemDividerSetting), 16'(SYS_DIV_RESET));
    waitRunning();
    $display("reset test done");
    foreach (rows[r]) begin
      setDiv(rows[r].sys, rows[r].core);
      step(1);
      chk(16'(systemDividerSetting), 16'(rows[r].expSet));
      step(150);
      measure(480);
      near(cnt[2], cnt[0] / int'(rows[r].expSet), 2);
      near(cnt[1], cnt[0] / (1 << rows[r].core), 2);
      near(cnt[3], cnt[2], 1);
      near(cnt[0], cnt[4] * 6, 8);
      near(cnt[5], cnt[4], 1);
      $display("divider row %0d done", r);
    end
    setMult(7'h04);
    step(1);
    setMult(7'h41);
    step(3);
    chk(16'(activeMultiplier), 16'(MULT_RESET));
    setMult(7'h08);
    step(200);
    chk(16'(activeMultiplier), 16'h0008);
    measure(480);
    near(cnt[0], cnt[4] * 8, 10);
    $display("multiplier test done");
    pllBypass = 1'b1;
    setMult(MULT_MIN);
    step(150);
    chk(16'(activeMultiplier), 16'h0008);
    measure(480);
    near(cnt[2], cnt[4], 2);
    near(cnt[1], cnt[4], 2);
    pllBypass = 1'b0;
    step(4);
    chk(16'(activeMultiplier), 16'(MULT_MIN));
    $display("bypass test done");
    sdramClockOutDisable = 1'b1;
    measure(200);
    chk(16'(cnt[3]), 16'h0000);
    sdramClockOutDisable = 1'b0;
    asyncClockOutDisable = 1'b1;
    measure(200);
    chk(16'(cnt[3]), 16'h0000);
    asyncClockOutDisable = 1'b0;
    $display("reference output test done");
    setFreq(REGULATOR_FREQUENCY_FIELD_HIBERNATE);
    step(1);
    chk(16'(regulatorWakeOut), 16'h0000);
    chk(16'(coreRunning), 16'h0000);
    measure(100);
    chk(16'(cnt[2] + cnt[1]), 16'h0000);
    setFreq(2'h3);
    step(1);
    chk(16'(regulatorWakeOut), 16'h0001);
    chk(16'(coreRunning), 16'h0000);
    waitRunning();
    $display("hibernation test done");
    finalReport();
  end
endmodule
`default_nettype wire
